// ===== rtl/rgbtg_pkg.sv
// package of constants for the rgb panel timing controller
// Summary of operation
// - 800 active pixel clocks per line
// - dot clock typical 40 MHz, never above 50
// - line total 862 to 1200 clocks
// - line sync width 1 to 40 clocks
// - horizontal front porch 16 to 354 clocks
// - 600 active lines per frame
// - frame sync width 1 to 20 lines
// - vertical front porch 1 to 77 lines
// - aim for about 60 Hz refresh
// - panel reset low at least 10 us
// - mode pin high selects data-enable timing
// - dither_disable high turns dithering off
// - eight bits per colour, narrow sources upper
package rgbtg_pkg;
  localparam int unsigned H_ACTIVE     = 800;  // active clocks per line
  localparam int unsigned H_BACK       = 46;   // fixed back porch
  localparam int unsigned H_SYNC_MIN   = 1;
  localparam int unsigned H_SYNC_MAX   = 40;
  localparam int unsigned H_SYNC_TYP   = 20;
  localparam int unsigned H_FRONT_MIN  = 16;
  localparam int unsigned H_FRONT_MAX  = 354;
  localparam int unsigned H_FRONT_TYP  = 210;
  localparam int unsigned H_TOTAL_MIN  = 862;
  localparam int unsigned H_TOTAL_MAX  = 1200;
  localparam int unsigned V_ACTIVE     = 600;  // active lines per frame
  localparam int unsigned V_BACK       = 23;   // fixed back porch
  localparam int unsigned V_SYNC_MIN   = 1;
  localparam int unsigned V_SYNC_MAX   = 20;
  localparam int unsigned V_SYNC_TYP   = 10;
  localparam int unsigned V_FRONT_MIN  = 1;
  localparam int unsigned V_FRONT_MAX  = 77;
  localparam int unsigned V_FRONT_TYP  = 12;
  localparam int unsigned V_TOTAL_MIN  = 624;
  localparam int unsigned V_TOTAL_MAX  = 700;
  localparam int unsigned MCLK_MHZ     = 250;  // system clock rate
  localparam int unsigned DOT_DIV      = 6;    // 250/6 MHz, under 50 MHz
  localparam int unsigned RST_US       = 10;   // least panel reset time
  localparam int unsigned RST_CYCLES   = RST_US * MCLK_MHZ;
  localparam int unsigned PIX_W        = 24;   // three 8-bit channels
  localparam int unsigned FIFO_DEPTH   = 16;
endpackage : rgbtg_pkg

// ===== rtl/rgbtg_fifo.sv
// pixel fifo with valid and ready on both sides
`timescale 1ns/1ps
module rgbtg_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;   // write pointer
    logic [AW-1:0] rd;   // read pointer
    logic [AW:0]   cnt;  // words held
  } rgbtg_fifo_st_t;
  rgbtg_fifo_st_t           st;
  rgbtg_fifo_st_t           next_st;
  logic [WIDTH-1:0]         mem [DEPTH];  // storage array
  logic                     push;
  logic                     pop;

  // honest full and empty from the count
  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = mem[st.rd];
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;

  // pointer and count update
  always_comb begin
    next_st = st;
    if (push) next_st.wr = st.wr + 1'b1;
    if (pop) next_st.rd = st.rd + 1'b1;
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) st <= '0;
    else if (clk_en) st <= next_st;
  end

  // storage write, no reset needed
  always_ff @(posedge mclk) begin
    if (push) mem[st.wr] <= in_data;
  end
endmodule : rgbtg_fifo

// ===== rtl/rgbtg_ctrl.sv
// rgb panel timing controller: dot clock, syncs, strobe, data, reset
`timescale 1ns/1ps
module rgbtg_ctrl #(
  parameter int unsigned H_SYNC    = rgbtg_pkg::H_SYNC_TYP,
  parameter int unsigned H_FRONT   = rgbtg_pkg::H_FRONT_TYP,
  parameter int unsigned V_SYNC    = rgbtg_pkg::V_SYNC_TYP,
  parameter int unsigned V_FRONT   = rgbtg_pkg::V_FRONT_TYP,
  parameter int unsigned RST_CYC   = rgbtg_pkg::RST_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,            // freezes all state when low
  input  wire logic        start,             // pulse: begin panel reset
  input  wire logic        sync_only_mode,    // level: use sync-only timing
  input  wire logic        dither_off,        // level: dithering disabled
  input  wire logic [23:0] pix_data,          // user pixel, r g b
  input  wire logic        pix_valid,
  output logic             pix_ready,
  output logic             dot_clock_in,      // dot clock to panel
  output logic             line_sync,         // active low line sync
  output logic             frame_sync,        // active low frame sync
  output logic             pixel_valid_strobe,
  output logic      [7:0]  red,
  output logic      [7:0]  green,
  output logic      [7:0]  blue,
  output logic             panel_mode,        // high: data-enable timing
  output logic             dither_disable,
  output logic             panel_reset_n,
  output logic             running,           // video is being sent
  output logic             underrun           // sticky: fifo ran dry
);
  // derived geometry, each total the sum of its parts
  localparam int unsigned HT = H_SYNC + rgbtg_pkg::H_BACK
                             + rgbtg_pkg::H_ACTIVE + H_FRONT;
  localparam int unsigned VT = V_SYNC + rgbtg_pkg::V_BACK
                             + rgbtg_pkg::V_ACTIVE + V_FRONT;
  localparam int unsigned H_DE0 = H_SYNC + rgbtg_pkg::H_BACK;
  localparam int unsigned V_DE0 = V_SYNC + rgbtg_pkg::V_BACK;

  typedef enum logic [1:0] {
    RGBTG_IDLE  = 2'b00,  // outputs quiet, panel held in reset
    RGBTG_RST   = 2'b01,  // panel reset pulse
    RGBTG_VIDEO = 2'b11   // streaming frames
  } rgbtg_state_t;

  typedef struct packed {
    rgbtg_state_t fsm;
    logic [17:0]  rcnt;    // reset pulse counter
    logic [2:0]   div;     // dot clock divider phase
    logic         dclk;    // dot clock level
    logic [10:0]  hcnt;    // position in line
    logic [9:0]   vcnt;    // position in frame
    logic         hs;
    logic         vs;
    logic         de;
    logic [23:0]  rgb;
    logic         rstn;
    logic         urun;
  } rgbtg_ctrl_st_t;

  rgbtg_ctrl_st_t st;
  rgbtg_ctrl_st_t next_st;
  logic [23:0]    f_data;   // fifo head
  logic           f_valid;
  logic           f_pop;    // take one pixel
  logic           fall;     // dot clock falling edge this cycle
  logic           h_act;
  logic           v_act;

  // pixel fifo; back-pressure reaches the user through pix_ready
  rgbtg_fifo #(
    .WIDTH (rgbtg_pkg::PIX_W),
    .DEPTH (rgbtg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_data   (pix_data),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // edge at which the panel sees new values: dot clock about to fall
  assign fall = st.dclk && (st.div == 3'(rgbtg_pkg::DOT_DIV / 2 - 1));

  // next-position windows for the strobe
  function automatic logic in_win(input int unsigned p,
                                  input int unsigned lo,
                                  input int unsigned n);
    in_win = (p >= lo) && (p < lo + n);
  endfunction : in_win

  // main next-state logic
  always_comb begin
    int unsigned hn;
    int unsigned vn;
    hn = 0;
    vn = 0;
    next_st = st;
    h_act = 1'b0;
    v_act = 1'b0;
    f_pop = 1'b0;
    unique case (st.fsm)
      RGBTG_IDLE: begin
        next_st.rstn = 1'b0;
        if (start) begin
          next_st.fsm  = RGBTG_RST;
          next_st.rcnt = '0;
        end
      end
      RGBTG_RST: begin
        next_st.rstn = 1'b0;
        // hold reset low for no less than the least time
        if (st.rcnt == 18'(RST_CYC - 1)) begin
          next_st.fsm  = RGBTG_VIDEO;
          next_st.rstn = 1'b1;
          next_st.hcnt = '0;
          next_st.vcnt = '0;
        end else begin
          next_st.rcnt = st.rcnt + 1'b1;
        end
      end
      RGBTG_VIDEO: begin
        // dot clock by divider, 250/6 MHz near 40 and under 50
        if (st.div == 3'(rgbtg_pkg::DOT_DIV / 2 - 1)) begin
          next_st.div  = '0;
          next_st.dclk = ~st.dclk;
        end else begin
          next_st.div = st.div + 1'b1;
        end
        // syncs, strobe and colour pins change together while the clock falls
        if (fall) begin
          hn = 32'(st.hcnt);
          vn = 32'(st.vcnt);
          // strobe over the 800 active pixels, 600 lines
          h_act = in_win(hn, H_DE0, rgbtg_pkg::H_ACTIVE);
          v_act = in_win(vn, V_DE0, rgbtg_pkg::V_ACTIVE);
          next_st.hs = !(hn < H_SYNC);
          next_st.vs = !(vn < V_SYNC);
          next_st.de = h_act && v_act;
          if (h_act && v_act) begin
            f_pop = f_valid;
            next_st.rgb = f_valid ? f_data : '0;
            if (!f_valid) next_st.urun = 1'b1;
          end else begin
            next_st.rgb = '0;
          end
          // advance position; front porches end line and frame
          if (hn == HT - 1) begin
            next_st.hcnt = '0;
            next_st.vcnt = (vn == VT - 1) ? '0 : st.vcnt + 1'b1;
          end else begin
            next_st.hcnt = st.hcnt + 1'b1;
          end
        end
      end
      default: next_st.fsm = RGBTG_IDLE;
    endcase
  end

  // state register, frozen by the clock enable
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st      <= '0;
      st.fsm  <= RGBTG_IDLE;
      st.hs   <= 1'b1;
      st.vs   <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // pin drive; channels msb-first, 8 bits each
  assign dot_clock_in       = st.dclk;
  assign line_sync          = st.hs;
  assign frame_sync         = st.vs;
  assign pixel_valid_strobe = st.de;
  assign red                = st.rgb[23:16];
  assign green              = st.rgb[15:8];
  assign blue               = st.rgb[7:0];
  assign panel_mode         = ~sync_only_mode;
  assign dither_disable     = dither_off;
  assign panel_reset_n      = st.rstn;
  assign running            = (st.fsm == RGBTG_VIDEO);
  assign underrun           = st.urun;
endmodule : rgbtg_ctrl

// ===== verif/rgbtg_props.sv
// concurrent checks on the rgb panel timing controller ports
`timescale 1ns/1ps
module rgbtg_props #(
  parameter int unsigned H_SYNC  = 20,
  parameter int unsigned RST_CYC = 2500
) (
  input wire logic       mclk, sys_rst, sync_only_mode, dither_off,
  input wire logic       dot_clock_in, line_sync, frame_sync, running,
  input wire logic       pixel_valid_strobe, panel_mode, dither_disable,
  input wire logic       panel_reset_n,
  input wire logic [7:0] red
);
  int unsigned low_cnt;  // cycles of panel reset held low
  int unsigned hs_cnt;   // cycles of line sync held low
  // measure the low phases of reset and line sync
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt <= 0;
      hs_cnt  <= 0;
    end else begin
      low_cnt <= panel_reset_n ? 0 : low_cnt + 1;
      hs_cnt  <= line_sync ? 0 : hs_cnt + 1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_MODE_PIN: assert property (panel_mode == !sync_only_mode)
    else $error("mode pin wrong");
  AST_DITHER_PIN: assert property (dither_disable == dither_off)
    else $error("dither pin wrong");
  AST_RESET_WIDTH: assert property ($rose(panel_reset_n) |->
    low_cnt >= RST_CYC) else $error("panel reset too short");
  AST_DOT_HIGH: assert property ($rose(dot_clock_in) |->
    dot_clock_in [*3] ##1 !dot_clock_in) else $error("dot high phase");
  AST_DOT_LOW: assert property ($fell(dot_clock_in) && running |->
    !dot_clock_in [*3] ##1 dot_clock_in) else $error("dot low phase");
  AST_ONE_EDGE: assert property ($changed({line_sync, frame_sync,
    pixel_valid_strobe, red}) |-> $fell(dot_clock_in))
    else $error("pins moved off the dot edge");
  AST_BLANK_DATA: assert property (!pixel_valid_strobe |->
    red == 8'h00) else $error("data outside active");
  AST_HS_WIDTH: assert property ($rose(line_sync) |->
    hs_cnt == H_SYNC * rgbtg_pkg::DOT_DIV) else $error("line sync width");
  AST_QUIET_RESET: assert property (!panel_reset_n |->
    line_sync && !pixel_valid_strobe) else $error("video during reset");
  cover property ($rose(panel_reset_n));
  cover property ($rose(pixel_valid_strobe));
  cover property ($rose(frame_sync));
endmodule : rgbtg_props
bind rgbtg_ctrl rgbtg_props #(.H_SYNC(H_SYNC), .RST_CYC(RST_CYC))
  rgbtg_props_i (.mclk, .sys_rst, .sync_only_mode, .dither_off,
  .dot_clock_in, .line_sync, .frame_sync, .running, .pixel_valid_strobe,
  .panel_mode, .dither_disable, .panel_reset_n, .red);

// ===== verif/rgbtg_panel.sv
// behavioural panel that samples the video stream and measures it
`timescale 1ns/1ps
module rgbtg_panel (
  input wire logic       mclk, dot_clock_in, line_sync, frame_sync,
  input wire logic       pixel_valid_strobe,
  input wire logic [7:0] red, green, blue,
  output int             line_clocks, act_count, act_line, sync_lines,
  output logic           seq_err
);
  logic        prev = 1'b0, hs_q = 1'b1, fs_q = 1'b1, seen = 1'b0;
  logic [23:0] last;  // previous pixel, r g b
  int          dots = 0, pix = 0, idx = 0;
  initial seq_err = 1'b0;
  // sample every pin on the rising dot edge
  always @(posedge mclk) begin
    prev <= dot_clock_in;
    if (dot_clock_in && !prev) begin
      hs_q <= line_sync;
      fs_q <= frame_sync;
      if (!line_sync && hs_q) begin // line period sync to sync
        line_clocks <= dots;
        dots = 1;
        idx = (!frame_sync && fs_q) ? 0 : idx + 1;
        if (frame_sync && !fs_q) sync_lines <= idx;
        if (pix != 0) act_count <= pix;
        pix = 0;
      end else dots = dots + 1;
      if (pixel_valid_strobe) begin
        if (pix == 0) act_line <= idx;
        pix = pix + 1;
        if (seen && {red, green, blue} !== last + 24'h1) seq_err <= 1;
        last = {red, green, blue};
        seen = 1'b1;
      end
    end
  end
endmodule : rgbtg_panel

// ===== verif/rgbtg_ctrl_tb.sv
// testbench of the rgb panel timing controller
`timescale 1ns/1ps
module rgbtg_ctrl_tb;
  localparam int unsigned RC = 20;  // short panel reset
  localparam int unsigned LN = 863 * 6;  // mclk cycles per line
  logic mclk = 0, sys_rst = 1, clk_en = 1, start = 0, pix_valid = 0;
  logic sync_only_mode = 0, dither_off = 0, seq_err;
  logic [23:0] pix_data = 24'h0;
  logic pix_ready, dot_clock_in, line_sync, frame_sync, pixel_valid_strobe;
  logic panel_mode, dither_disable, panel_reset_n, running, underrun;
  logic [7:0] red, green, blue;
  int line_clocks, act_count, act_line, sync_lines;
  int bad_count = 0, compares = 0, n;
  // legal geometry: porches and totals in range
  rgbtg_ctrl #(.H_SYNC(1), .H_FRONT(16), .V_SYNC(1), .V_FRONT(12),
    .RST_CYC(RC)) rgbtg_ctrl_i (.mclk, .sys_rst, .clk_en, .start,
    .sync_only_mode, .dither_off, .pix_data, .pix_valid, .pix_ready,
    .dot_clock_in, .line_sync, .frame_sync, .pixel_valid_strobe, .red,
    .green, .blue, .panel_mode, .dither_disable, .panel_reset_n, .running,
    .underrun);
  rgbtg_panel rgbtg_panel_i (.mclk, .dot_clock_in, .line_sync, .frame_sync,
    .pixel_valid_strobe, .red, .green, .blue, .line_clocks, .act_count,
    .act_line, .sync_lines, .seq_err);
  always #2 mclk = ~mclk;
  // next pixel once the current one is taken
  always @(posedge mclk) if (pix_valid && pix_ready) pix_data <= pix_data + 24'h1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task t_pins;
    for (n = 0; n < 4; n++) begin
      @(negedge mclk) {sync_only_mode, dither_off} = n[1:0];
      #1 check(panel_mode, !n[1]);
      check(dither_disable, n[0]);
    end
    {sync_only_mode, dither_off} = 2'b00;
  endtask : t_pins
  task t_reset;
    @(negedge mclk) start = 1;
    @(negedge mclk) start = 0;
    for (n = 0; !panel_reset_n && n < RC + 10; n++) @(negedge mclk);
    check(n >= RC, 1);
    check(running, 1);
  endtask : t_reset
  task t_line;
    repeat (2 * LN + 100) @(negedge mclk);
    check(line_clocks, 863);
    check(sync_lines, 1);
  endtask : t_line
  task t_active;
    for (n = 0; act_count == 0 && n < 30 * LN; n++) @(negedge mclk);
    check(act_count, 800);
    check(act_line, 24);
    check(seq_err, 0);
    check(underrun, 0);
  endtask : t_active
  task t_underrun;
    pix_valid = 0;
    repeat (LN + 60) @(negedge mclk);
    check(underrun, 1);
    check(act_count, 800);
  endtask : t_underrun
  initial begin
    repeat (6) @(negedge mclk);
    check(panel_reset_n, 0);
    sys_rst = 0;
    t_pins;
    pix_valid = 1;
    t_reset;
    t_line;
    t_active;
    t_underrun;
    give_verdict;
  end
  // cut a hang short
  initial begin
    #800000;
    bad_count++;
    give_verdict;
  end
endmodule : rgbtg_ctrl_tb
